// ### rtl/port_measure_overcurrent.sv
`timescale 1ns/1ps
module port_measure_overcurrent
    import port_measure_pkg::*;
(
    input  wire logic                          mclk,           // 50 MHz clock
    input  wire logic                          reset,          // Sync reset, active high
    input  wire logic [NUM_PORTS*SAMPLE_W-1:0] currentLimit,   // Per-port limit, mA
    input  wire logic [NUM_PORTS-1:0]          portEnable,     // Software power enable
    input  wire logic [NUM_PORTS-1:0]          flagClear,      // Software flag clear pulse
    input  wire logic                          upstreamOnly,   // Powered from first_upstream_port only
    output logic      [CHAN_W-1:0]             convChan,       // Channel being converted
    output logic                               convStart,      // Pulse: start a conversion
    input  wire logic                          convValid,      // Pulse: sample ready
    input  wire logic [SAMPLE_W-1:0]           convData,       // Raw sample
    output logic      [NUM_CHANS*SAMPLE_W-1:0] filtOut,        // Filtered results, all channels
    output logic                               filtUpdate,     // Pulse: one result updated
    output logic      [NUM_PORTS-1:0]          overcurrent,    // Sticky overcurrent flags
    output logic      [NUM_PORTS-1:0]          powerOn         // Port power switch drive
);
    // ------------------------------------------------------------
    // Schedule table: ports in triples, V/I interleaved, then supply
    // ------------------------------------------------------------
    // One round of SLOTS slots, three groups of six:
    //   group 0: V0 V1 V2 I0 I1 I2
    //   group 1: V3 V4 V5 I3 I4 I5
    //   group 2: V6 V7 S  I6 I7 S
    // The supply fills the missing ninth port position, so every port
    // current is converted once per round and the supply twice.
    // interleaved schedule
    function automatic logic [CHAN_W-1:0] slotChan(input logic [CHAN_W-1:0] s);
        logic [CHAN_W-1:0] grp;
        logic [CHAN_W-1:0] rem;
        grp = CHAN_W'(s / 5'd6);
        rem = CHAN_W'(s % 5'd6);
        // Channel = 2*port + (0 voltage, 1 current); port 8 is the supply
        slotChan = CHAN_W'((grp * 5'd3 + rem % 5'd3) * 5'd2 + rem / 5'd3);
        if (slotChan >= CHAN_W'(NUM_CHANS - 1)) begin
            slotChan = SUPPLY_CHAN;
        end
    endfunction : slotChan

    // ------------------------------------------------------------
    // Sequencer and filter state
    // ------------------------------------------------------------
    meas_state_t             state_reg;
    logic [CHAN_W-1:0]       slot_reg;
    logic [SLOT_CNT_W-1:0]   slotCnt_reg;
    logic [SAMPLE_W-1:0]     sample_reg;
    logic signed [SAMPLE_W+1:0] accum_reg;
    logic [SAMPLE_W-1:0]     prevOut;
    logic [SAMPLE_W-1:0]     newOut;
    logic                    slotDone;
    logic                    wrEn;
    logic [SAMPLE_W-1:0]     prevUse;
    logic [NUM_CHANS-1:0]    seeded_reg;

    // Channel follows the slot index; it stays put for a whole slot
    assign convChan = slotChan(slot_reg);
    assign slotDone = (slotCnt_reg == SLOT_CNT_W'(SLOT_CYCLES - 1));

    // ------------------------------------------------------------
    // Slot timer
    // ------------------------------------------------------------
    // The schedule is paced by this timer, never by the converter's
    // answer, so a slow or missing sample cannot stretch a round.
    // fixed slot
    always_ff @(posedge mclk) begin
        if (reset || slotDone) begin
            slotCnt_reg <= '0;
        end else begin
            slotCnt_reg <= slotCnt_reg + 1'b1;
        end
    end

    // Start pulse at the head of each slot
    // Registered, so the pulse is clean one cycle after the count wraps
    always_ff @(posedge mclk) begin
        convStart <= reset ? 1'b0 : (slotCnt_reg == '0);
    end

    // ------------------------------------------------------------
    // Convert / filter sequencer
    // ------------------------------------------------------------
    // sequencing
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= ST_CONVERT;
            slot_reg  <= '0;
        end else begin
            // Samples offered in the two filter cycles are refused; the
            // converter is expected to answer once per slot.
            unique case (state_reg)
                ST_CONVERT: begin
                    if (convValid) begin
                        state_reg <= ST_FILTER;
                    end
                end
                ST_FILTER: state_reg <= ST_WRITE;
                ST_WRITE: begin
                    state_reg <= ST_CONVERT;
                end
            endcase
            // Advance only at slot end; a missed sample keeps old output
            if (slotDone) begin
                slot_reg <= (slot_reg == CHAN_W'(SLOTS - 1)) ? '0 : slot_reg + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Averaging filter
    // ------------------------------------------------------------
    // Channels not yet written read as zero, the same as the cleared
    // mirror, so the filter rises from zero instead of from an unknown
    // store word. The store itself has no reset to keep it a plain RAM.
    always_ff @(posedge mclk) begin
        if (reset) begin
            seeded_reg <= '0;
        end else if (wrEn) begin
            seeded_reg[convChan] <= 1'b1;
        end
    end
    assign prevUse = seeded_reg[convChan] ? prevOut : '0;

    // Capture sample, then quarter difference
    // The difference is formed on 14 signed bits so a fall never wraps
    // averaging
    always_ff @(posedge mclk) begin
        if (reset) begin
            sample_reg <= '0;
            accum_reg  <= '0;
        end else if (state_reg == ST_CONVERT && convValid) begin
            sample_reg <= convData;
        end else if (state_reg == ST_FILTER) begin
            accum_reg <= ($signed({2'b00, sample_reg}) - $signed({2'b00, prevUse})) >>> FILTER_SHIFT;
        end
    end

    // Truncating shift never overshoots, so the sum stays in range
    // A rising input is left up to three counts short; above 300 counts
    // that residue stays inside the one percent settling band.
    assign newOut = SAMPLE_W'($signed({2'b00, prevUse}) + accum_reg);
    assign wrEn   = (state_reg == ST_WRITE);

    filter_store u_store (
        .mclk   (mclk),
        .rdAddr (convChan),
        .rdData (prevOut),
        .wrEn   (wrEn),
        .wrAddr (convChan),
        .wrData (newOut)
    );

    // ------------------------------------------------------------
    // Result mirror
    // ------------------------------------------------------------
    // Mirror of results for software, flopped
    always_ff @(posedge mclk) begin
        if (reset) begin
            filtOut    <= '0;
            filtUpdate <= 1'b0;
        end else begin
            filtUpdate <= wrEn;
            if (wrEn) begin
                filtOut[convChan*SAMPLE_W +: SAMPLE_W] <= newOut;
            end
        end
    end

    // ------------------------------------------------------------
    // Per-port trip logic
    // ------------------------------------------------------------
    // Each port owns a flag, a delay counter and an off latch. The off
    // latch only clears when the flag does, so a tripped port stays
    // dark until software clears the flag or re-enables the port.
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            logic [TRIP_CNT_W-1:0] tripCnt_reg;
            logic                  off_reg;
            logic                  hit;
            logic                  enPrev_reg;
            assign hit = convValid && (state_reg == ST_CONVERT) &&
                         (convChan == CHAN_W'(2 * p + 1)) &&
                         (convData > currentLimit[p*SAMPLE_W +: SAMPLE_W]);

            always_ff @(posedge mclk) begin
                if (reset) begin
                    overcurrent[p] <= 1'b0;
                end else if (hit) begin
                    overcurrent[p] <= 1'b1;
                end else if (flagClear[p] || (portEnable[p] && !enPrev_reg)) begin
                    overcurrent[p] <= 1'b0;
                end
            end

            // Re-enable edge detect; follows the pin through reset, so a
            // port held enabled across reset shows no false edge after it
            always_ff @(posedge mclk) begin
                enPrev_reg <= portEnable[p];
            end

            // The counter holds at its end value, so the latch cannot wrap
            // delayed switch-off
            always_ff @(posedge mclk) begin
                if (reset || !overcurrent[p]) begin
                    tripCnt_reg <= '0;
                    off_reg     <= 1'b0;
                end else if (tripCnt_reg == TRIP_CNT_W'(TRIP_CYCLES - 1)) begin
                    off_reg     <= 1'b1;
                end else begin
                    tripCnt_reg <= tripCnt_reg + 1'b1;
                end
            end

            // Registered so the switch never sees a glitch from the decode
            // no power from upstream bus
            always_ff @(posedge mclk) begin
                powerOn[p] <= !reset && portEnable[p] && !off_reg && !upstreamOnly;
            end
        end
    endgenerate
endmodule : port_measure_overcurrent

// ### rtl/port_measure_pkg.sv
// Notes on behaviour
// - Measure voltage, current of eight ports, supply.
// - Port voltage then current, interleaved with others.
// - Each conversion slot lasts 140 us.
// - Output plus quarter of sample-output difference.
// - Update filter before converting next signal.
// - Step settles 10% in 8, 1% in 16.
// - Trip compares raw current, not filtered.
// - Any sample above limit trips that port.
// - Flag at once, switch off after delay.
// - Limit programmable 0 to 4095 mA, 1 mA.
// - Upstream bus power only keeps ports off.
package port_measure_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_PORTS   = 8;
    localparam int SAMPLE_W    = 12;
    localparam int NUM_CHANS   = 2 * NUM_PORTS + 1;
    localparam int CHAN_W      = 5;
    localparam int SLOTS       = 18;
    localparam int FILTER_SHIFT = 2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 50;
    localparam int SLOT_US        = 140;
    localparam int SLOT_CYCLES    = SLOT_US * CLK_MHZ;
    localparam int TRIP_DELAY_US  = 1000;
    localparam int TRIP_CYCLES    = TRIP_DELAY_US * CLK_MHZ;
    localparam int SLOT_CNT_W     = 13;
    localparam int TRIP_CNT_W     = 16;

    localparam logic [SAMPLE_W-1:0] LIMIT_RESET = 12'hfff;
    localparam logic [CHAN_W-1:0]   SUPPLY_CHAN = 5'h10;

    typedef enum logic [1:0] { ST_CONVERT, ST_FILTER, ST_WRITE } meas_state_t;
endpackage : port_measure_pkg

// ### rtl/filter_store.sv
`timescale 1ns/1ps
// Small store of the filtered outputs, one word per channel
module filter_store
    import port_measure_pkg::*;
(
    input  wire logic                mclk,      // System clock
    input  wire logic [CHAN_W-1:0]   rdAddr,    // Read channel
    output logic      [SAMPLE_W-1:0] rdData,    // Registered read data
    input  wire logic                wrEn,      // Write strobe
    input  wire logic [CHAN_W-1:0]   wrAddr,    // Write channel
    input  wire logic [SAMPLE_W-1:0] wrData     // Write data
);
    logic [SAMPLE_W-1:0] mem [0:NUM_CHANS-1];

    // ------------------------------------------------------------
    // Registered read, plain write
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule : filter_store

// ### sim/port_measure_overcurrent_asserts.sv
`timescale 1ns/1ps
module port_measure_overcurrent_asserts
    import port_measure_pkg::*;
(
    input wire logic                          mclk,         // Clock
    input wire logic                          reset,        // Reset
    input wire logic [NUM_PORTS*SAMPLE_W-1:0] currentLimit, // Limits
    input wire logic [NUM_PORTS-1:0]          portEnable,   // Enables
    input wire logic [NUM_PORTS-1:0]          flagClear,    // Clears
    input wire logic                          upstreamOnly, // Bus powered
    input wire logic [CHAN_W-1:0]             convChan,     // Channel
    input wire logic                          convStart,    // Start
    input wire logic                          convValid,    // Ready
    input wire logic [SAMPLE_W-1:0]           convData,     // Sample
    input wire logic                          filtUpdate,   // Update
    input wire logic [NUM_PORTS-1:0]          overcurrent,  // Flags
    input wire logic [NUM_PORTS-1:0]          powerOn       // Switches
);
    logic [12:0] slotCnt_reg;
    logic [17:0] tripCnt_reg;
    logic        seen_reg;
    // Counters, since the long spans are too big for repetition
    always_ff @(posedge mclk) begin
        slotCnt_reg <= (reset || convStart) ? 13'h0 : slotCnt_reg + 13'h1;
        seen_reg    <= reset ? 1'b0 : (seen_reg | convStart);
        tripCnt_reg <= overcurrent[0] ? tripCnt_reg + 18'h1 : 18'h0;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_curSample;
        convValid && convChan[0] && convChan != SUPPLY_CHAN;
    endsequence
    property p_slot;
        convStart && seen_reg |-> slotCnt_reg == 13'(SLOT_CYCLES - 1);
    endproperty
    a_slot: assert property (p_slot) else $error("slot length wrong");
    property p_trip;
        s_curSample ##0 (convData > currentLimit[convChan[3:1]*SAMPLE_W +: SAMPLE_W]) |=> overcurrent[convChan[3:1]];
    endproperty
    a_trip: assert property (p_trip) else $error("trip missed");
    property p_raw;
        (overcurrent & ~$past(overcurrent)) != 8'h0 |-> $past(convValid) && $past(convChan[0]);
    endproperty
    a_raw: assert property (p_raw) else $error("flag without current sample");
    property p_upd;
        convValid |-> ##3 filtUpdate;
    endproperty
    a_upd: assert property (p_upd) else $error("filter update late");
    property p_pulse;
        filtUpdate |=> !filtUpdate;
    endproperty
    a_pulse: assert property (p_pulse) else $error("update not a pulse");
    property p_delay;
        $fell(powerOn[0]) && overcurrent[0] && $past(portEnable[0]) && !$past(upstreamOnly)
            |-> tripCnt_reg >= 18'd49990 && tripCnt_reg <= 18'd170000;
    endproperty
    a_delay: assert property (p_delay) else $error("switch-off delay wrong");
    property p_up;
        upstreamOnly && $past(upstreamOnly) |-> powerOn == 8'h0;
    endproperty
    a_up: assert property (p_up) else $error("port powered from upstream");
    property p_sticky;
        overcurrent[0] && !flagClear[0] && !$rose(portEnable[0]) |=> overcurrent[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
endmodule : port_measure_overcurrent_asserts

// ### sim/conv_model.sv
`timescale 1ns/1ps
module conv_model
    import port_measure_pkg::*;
(
    input  wire logic                mclk,      // Clock
    input  wire logic [CHAN_W-1:0]   convChan,  // Channel
    input  wire logic                convStart, // Start
    input  wire logic                slow,      // Long conversion
    input  wire logic [SAMPLE_W-1:0] voltVal,   // Voltage level
    input  wire logic [SAMPLE_W-1:0] currVal,   // Current level
    output logic                     convValid, // Ready
    output logic      [SAMPLE_W-1:0] convData   // Sample
);
    initial begin
        convValid = 1'b0;
        convData  = 12'h5a5;
    end
    // One sample per start; data inverted when not offered so stale values never match
    always @(posedge mclk) begin
        if (convStart) begin
            repeat (slow ? 200 : 3) @(posedge mclk);
            #1 convValid = 1'b1;
            convData = convChan[0] ? currVal : voltVal;
            @(posedge mclk);
            #1 convValid = 1'b0;
            convData = ~convData;
        end
    end
endmodule : conv_model

// ### sim/port_measure_overcurrent_test.sv
`timescale 1ns/1ps
module port_measure_overcurrent_test import port_measure_pkg::*;;
    logic                          mclk = 1'b0;
    logic                          reset = 1'b1;
    logic [NUM_PORTS*SAMPLE_W-1:0] currentLimit;
    logic [NUM_PORTS-1:0]          portEnable, flagClear, overcurrent, powerOn;
    logic                          upstreamOnly, convStart, convValid, filtUpdate, slowConv;
    logic [CHAN_W-1:0]             convChan;
    logic [SAMPLE_W-1:0]           convData;
    logic [NUM_CHANS*SAMPLE_W-1:0] filtOut;
    int                            failCount = 0;
    int                            checks = 0;
    int                            cyc = 0;
    always #10 mclk = ~mclk;
    port_measure_overcurrent u_dut (.mclk, .reset, .currentLimit, .portEnable, .flagClear, .upstreamOnly,
        .convChan, .convStart, .convValid, .convData, .filtOut, .filtUpdate, .overcurrent, .powerOn);
    conv_model u_conv (.mclk, .convChan, .convStart, .slow(slowConv), .voltVal(12'hfff), .currVal(12'h100),
        .convValid, .convData);
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic checkWord(string what, logic [SAMPLE_W-1:0] exp, logic [SAMPLE_W-1:0] got);
        checks++;
        if (got !== exp) begin
            failCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : checkWord
    task automatic report_and_stop();
        if (failCount == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // Hang guard: the run needs about 84000 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 98000) begin
            failCount++;
            report_and_stop();
        end
    end
    function automatic logic [7:0] slotChan(int s);
        int r = s % 6;
        int p = 3 * (s / 6) + r % 3;
        return (p == 8) ? 8'h10 : 8'(2 * p + (r >= 3));
    endfunction : slotChan
    task automatic t_schedule();
        for (int s = 0; s < 13; s++) begin
            do begin @(posedge mclk); #1; end while (convStart !== 1'b1);
            check("convChan", slotChan(s), 8'(convChan));
        end
    endtask : t_schedule
    task automatic t_upstream();
        repeat (3000) @(posedge mclk);
        #1 check("powerOn", 8'hff, powerOn);
        upstreamOnly = 1'b1;
        repeat (3) @(posedge mclk);
        #1 check("powerOn", 8'h00, powerOn);
        upstreamOnly = 1'b0;
        slowConv = 1'b0;
        repeat (3) @(posedge mclk);
        #1 check("powerOn", 8'hff, powerOn);
    endtask : t_upstream
    // Port 0 trips at slot 3, port 1 sits at its limit, port 3 has a zero limit
    task automatic t_trip();
        wait (cyc == 21000);
        #1 check("overcurrent", 8'h00, overcurrent);
        wait (cyc == 21100);
        #1 check("overcurrent", 8'h01, overcurrent);
        wait (cyc == 70900);
        #1 check("overcurrent", 8'h09, overcurrent);
        check("powerOn", 8'hff, powerOn);
        wait (cyc == 71200);
        #1 check("powerOn", 8'hfe, powerOn);
        wait (cyc == 80000);
        #1 check("powerOn", 8'hfe, powerOn);
        flagClear = 8'h01;
        @(posedge mclk);
        #1 flagClear = 8'h00;
        repeat (2) @(posedge mclk);
        #1 check("overcurrent", 8'h08, overcurrent);
        check("powerOn", 8'hff, powerOn);
        portEnable = 8'hf7;
        @(posedge mclk);
        #1 portEnable = 8'hff;
        repeat (2) @(posedge mclk);
        #1 check("overcurrent", 8'h00, overcurrent);
    endtask : t_trip
    // Port 0 voltage lands in slot 0, its current in slot 3, both from zero
    task automatic t_filter();
        wait (cyc == 20000);
        #1 checkWord("filtOut V0", 12'h3ff, filtOut[0 +: SAMPLE_W]);
        checkWord("filtOut I0", 12'h000, filtOut[SAMPLE_W +: SAMPLE_W]);
        wait (cyc == 28000);
        #1 checkWord("filtOut I0", 12'h040, filtOut[SAMPLE_W +: SAMPLE_W]);
    endtask : t_filter
    initial begin
        currentLimit = {{4{12'hfff}}, 12'h000, 12'hfff, 12'h100, 12'h0ff};
        portEnable = 8'hff;
        flagClear = 8'h00;
        upstreamOnly = 1'b0;
        slowConv = 1'b1;
        repeat (16) @(posedge mclk);
        #1 reset = 1'b0;
        fork
            t_schedule();
            t_upstream();
            t_trip();
            t_filter();
        join
        report_and_stop();
    end
endmodule : port_measure_overcurrent_test
bind port_measure_overcurrent port_measure_overcurrent_asserts u_chk (.mclk, .reset, .currentLimit, .portEnable,
    .flagClear, .upstreamOnly, .convChan, .convStart, .convValid, .convData, .filtUpdate, .overcurrent, .powerOn);
